// ===== hw/mlcr_pkg.sv
// Constants, register map and helper functions for the multipoint link configuration registers
// How it works
// - Mask bit 0 set inserts a start-of-block control marker into inbound data.
// - Mask bit 1 set inserts an end-of-block marker after an ETX-ended block.
// - Mask bit 2 set inserts a continued-block marker after an ETB-ended block.
// - One speed code drives both transmit and receive; no split rates.
// - Speed codes 0 and 7 to 15 select external clock or 300-19200 baud.
// - Group and device identifier take codes 0-26, meaning '@' then A-Z.
// - Handshake register picks the modem handshake type; 0 turns it off.
// - No character-level flow control; the network host decides every transfer.
// - Block size zero caps each transmitted block at 512 bytes.
// - Block size N caps each transmitted block at 2*N characters.
// - Parity register accepts only 0 for none and 1 for odd.
// - Registers 25-35 and 37-62 do nothing; writes leave link behaviour alone.
// - Odd parity sets the bit on an even count of ones and checks received characters.
// - Handshake on drops data while carrier is low and holds transmit while CTS is low.
package mlcr_pkg;
  localparam logic [5:0] IDX_CB_MASK = 6'h0E;
  localparam logic [5:0] IDX_SPEED = 6'h14;
  localparam logic [5:0] IDX_GROUP = 6'h15;
  localparam logic [5:0] IDX_DEVICE = 6'h16;
  localparam logic [5:0] IDX_HS = 6'h17;
  localparam logic [5:0] IDX_BSIZE = 6'h18;
  localparam logic [5:0] IDX_PARITY = 6'h24;
  localparam logic [5:0] IDX_STATUS = 6'h3F;
  localparam logic [7:0] RST_CB_MASK = 8'h00;
  localparam logic [7:0] RST_SPEED = 8'h0E;
  localparam logic [7:0] RST_GROUP = 8'h01;
  localparam logic [7:0] RST_DEVICE = 8'h01;
  localparam logic [7:0] RST_HS = 8'h00;
  localparam logic [7:0] RST_BSIZE = 8'h00;
  localparam logic [7:0] RST_PARITY = 8'h00;
  localparam int MASK_START_BIT = 0;
  localparam int MASK_ETX_BIT = 1;
  localparam int MASK_ETB_BIT = 2;
  localparam int STAT_PERR_BIT = 0;
  localparam int STAT_DCD_BIT = 1;
  localparam int STAT_CTS_BIT = 2;
  localparam logic [7:0] ID_MAX = 8'h1A;
  localparam logic [7:0] ID_CHAR_BASE = 8'h40;
  localparam logic [7:0] HS_MAX = 8'h03;
  localparam logic [7:0] PAR_NONE = 8'h00;
  localparam logic [7:0] PAR_ODD = 8'h01;
  localparam logic [7:0] SPEED_EXT = 8'h00;
  localparam logic [7:0] CB_START = 8'h02;
  localparam logic [7:0] CB_ETX = 8'h03;
  localparam logic [7:0] CB_ETB = 8'h17;
  localparam logic [9:0] BLOCK_MAX = 10'h200;
  localparam int CLK_HZ_DEFAULT = 100000000;

  typedef enum logic [1:0] {MLCR_DATA, MLCR_START, MLCR_ETX, MLCR_ETB} mlcr_kind_type;

  function automatic int baud_of(input logic [7:0] code);
    unique case (code)
      8'h07: baud_of = 300;
      8'h08: baud_of = 600;
      8'h09: baud_of = 1200;
      8'h0A: baud_of = 1800;
      8'h0B: baud_of = 2400;
      8'h0C: baud_of = 3600;
      8'h0D: baud_of = 4800;
      8'h0E: baud_of = 9600;
      8'h0F: baud_of = 19200;
      default: baud_of = 0;
    endcase
  endfunction

  function automatic logic speed_ok(input logic [7:0] code);
    speed_ok = (code == SPEED_EXT) || (baud_of(code) != 0);
  endfunction

  function automatic logic odd_bit(input logic [7:0] d);
    odd_bit = ~(^d);
  endfunction
endpackage

// ===== hw/mlcr_sync2.sv
// Two-flop synchroniser for one asynchronous level
`timescale 1ns/10ps
module mlcr_sync2 (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic d,
  output logic q
);
  logic meta;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= 1'b0;
      q <= 1'b0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

// ===== hw/mlcr_baud.sv
// Bit-rate tick generator shared by transmit and receive
`timescale 1ns/10ps
module mlcr_baud
  import mlcr_pkg::*;
#(
  parameter int CLK_HZ = CLK_HZ_DEFAULT
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] speed,
  input wire logic ext_clk_s,
  output logic tick
);
  logic [19:0] cnt;
  logic ext_prev;
  logic use_ext;
  logic [19:0] div;
  logic ext_rise;
  logic wrap;

  assign use_ext = (speed == SPEED_EXT);
  // Speed register only ever holds a legal code, so baud_of is nonzero here
  assign div = use_ext ? 20'h00001 : 20'(CLK_HZ / (baud_of(speed) == 0 ? 1 : baud_of(speed)));
  assign ext_rise = ext_clk_s & ~ext_prev;
  assign wrap = (cnt >= div - 20'h00001);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 20'h00000;
      ext_prev <= 1'b0;
      tick <= 1'b0;
    end else begin
      ext_prev <= ext_clk_s;
      cnt <= (use_ext || wrap) ? 20'h00000 : cnt + 20'h00001;
      tick <= use_ext ? ext_rise : wrap;
    end
  end

  chk_ext_only_edge: assert property (@(posedge pclk) disable iff (!presetn)
    use_ext && !ext_rise |=> !tick) else $error("tick without external clock edge");
  chk_int_period: assert property (@(posedge pclk) disable iff (!presetn)
    !use_ext && wrap && $stable(speed) |=> tick) else $error("internal tick missing at divider wrap");
  cov_ext_tick: cover property (@(posedge pclk) disable iff (!presetn) use_ext && tick);
endmodule

// ===== hw/mlcr_top.sv
// APB configuration registers and inbound/outbound stream handling for the multipoint link
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/10ps
module mlcr_top
  import mlcr_pkg::*;
#(
  parameter int CLK_HZ = CLK_HZ_DEFAULT
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic dcd_pin,
  input wire logic cts_pin,
  input wire logic ext_clk_pin,
  input wire logic rx_valid,
  input wire mlcr_kind_type rx_kind,
  input wire logic [7:0] rx_data,
  input wire logic rx_par,
  output logic in_valid,
  output logic in_ctrl,
  output logic [7:0] in_data,
  output logic in_perr,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  output logic tx_ready,
  output logic tx_char_valid,
  output logic [7:0] tx_char,
  output logic tx_par_en,
  output logic tx_parity,
  output logic tx_block_end,
  output logic baud_tick,
  output logic [7:0] group_identifier_char,
  output logic [7:0] device_identifier_char
);
  logic [7:0] control_block_mask;
  logic [7:0] line_speed_select;
  logic [7:0] group_identifier;
  logic [7:0] device_identifier;
  logic [7:0] hardware_handshake_type;
  logic [7:0] transmit_block_size;
  logic [7:0] parity_select;
  logic perr_sticky;
  logic [9:0] tx_cnt;
  logic dcd_s;
  logic cts_s;
  logic ext_s;

  mlcr_sync2 u_sync_dcd (.pclk(pclk), .presetn(presetn), .d(dcd_pin), .q(dcd_s));
  mlcr_sync2 u_sync_cts (.pclk(pclk), .presetn(presetn), .d(cts_pin), .q(cts_s));
  mlcr_sync2 u_sync_ext (.pclk(pclk), .presetn(presetn), .d(ext_clk_pin), .q(ext_s));

  // One generator serves both directions
  mlcr_baud #(.CLK_HZ(CLK_HZ)) u_baud (
    .pclk(pclk),
    .presetn(presetn),
    .speed(line_speed_select),
    .ext_clk_s(ext_s),
    .tick(baud_tick)
  );

  // APB decode: printed offsets are register indexes, byte address is four times that
  wire [5:0] idx = paddr[7:2];
  wire wr_en = psel & penable & pready & pwrite & pstrb[0];
  wire rd_setup = psel & ~penable & ~pwrite;
  wire [7:0] wd = pwdata[7:0];
  wire wr_mask = wr_en && idx == IDX_CB_MASK;
  wire wr_speed = wr_en && idx == IDX_SPEED && speed_ok(wd);
  wire wr_group = wr_en && idx == IDX_GROUP && wd <= ID_MAX;
  wire wr_device = wr_en && idx == IDX_DEVICE && wd <= ID_MAX;
  wire wr_hs = wr_en && idx == IDX_HS && wd <= HS_MAX;
  wire wr_bsize = wr_en && idx == IDX_BSIZE;
  wire wr_parity = wr_en && idx == IDX_PARITY && wd <= PAR_ODD;
  wire wr_status = wr_en && idx == IDX_STATUS;
  wire [7:0] status_val = {5'h00, cts_s, dcd_s, perr_sticky};
  logic [7:0] rd_val;

  // Unlisted indexes, including the unused ranges, read zero and ignore writes
  always_comb begin
    unique case (idx)
      IDX_CB_MASK: rd_val = control_block_mask;
      IDX_SPEED: rd_val = line_speed_select;
      IDX_GROUP: rd_val = group_identifier;
      IDX_DEVICE: rd_val = device_identifier;
      IDX_HS: rd_val = hardware_handshake_type;
      IDX_BSIZE: rd_val = transmit_block_size;
      IDX_PARITY: rd_val = parity_select;
      IDX_STATUS: rd_val = status_val;
      default: rd_val = 8'h00;
    endcase
  end

  // No wait state; prdata and pready still come straight from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel & ~penable;
      pslverr <= 1'b0;
      if (rd_setup) begin
        prdata <= {24'h000000, rd_val};
      end
    end
  end

  // Illegal codes are dropped so the registers always hold a usable setting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_block_mask <= RST_CB_MASK;
      line_speed_select <= RST_SPEED;
      group_identifier <= RST_GROUP;
      device_identifier <= RST_DEVICE;
      hardware_handshake_type <= RST_HS;
      transmit_block_size <= RST_BSIZE;
      parity_select <= RST_PARITY;
    end else begin
      if (wr_mask) control_block_mask <= wd;
      if (wr_speed) line_speed_select <= wd;
      if (wr_group) group_identifier <= wd;
      if (wr_device) device_identifier <= wd;
      if (wr_hs) hardware_handshake_type <= wd;
      if (wr_bsize) transmit_block_size <= wd;
      if (wr_parity) parity_select <= wd;
    end
  end

  // Identifier characters used when matching polls
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      group_identifier_char <= ID_CHAR_BASE + RST_GROUP;
      device_identifier_char <= ID_CHAR_BASE + RST_DEVICE;
    end else begin
      group_identifier_char <= ID_CHAR_BASE + group_identifier;
      device_identifier_char <= ID_CHAR_BASE + device_identifier;
    end
  end

  // Inbound path
  wire hs_on = hardware_handshake_type != RST_HS;
  wire odd_on = parity_select == PAR_ODD;
  wire rx_drop = hs_on & ~dcd_s;
  wire rx_is_data = rx_valid && rx_kind == MLCR_DATA;
  wire rx_bad_par = odd_on && ((^rx_data) ^ rx_par) == 1'b0;
  wire mk_start = rx_valid && rx_kind == MLCR_START && control_block_mask[MASK_START_BIT];
  wire mk_etx = rx_valid && rx_kind == MLCR_ETX && control_block_mask[MASK_ETX_BIT];
  wire mk_etb = rx_valid && rx_kind == MLCR_ETB && control_block_mask[MASK_ETB_BIT];
  wire take_data = rx_is_data & ~rx_drop;
  wire [7:0] next_marker = mk_start ? CB_START : (mk_etx ? CB_ETX : CB_ETB);
  wire perr_set = take_data & rx_bad_par;
  wire perr_clr = wr_status & wd[STAT_PERR_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_valid <= 1'b0;
      in_ctrl <= 1'b0;
      in_data <= 8'h00;
      in_perr <= 1'b0;
    end else begin
      in_valid <= take_data | mk_start | mk_etx | mk_etb;
      in_ctrl <= ~rx_is_data;
      in_data <= rx_is_data ? rx_data : next_marker;
      in_perr <= rx_is_data & rx_bad_par;
    end
  end

  // Set wins over a software clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      perr_sticky <= 1'b0;
    end else begin
      perr_sticky <= perr_set | (perr_sticky & ~perr_clr);
    end
  end

  // Outbound path: characters pass untouched; no flow-control characters are made or stripped
  wire [9:0] blk_limit = (transmit_block_size == RST_BSIZE) ? BLOCK_MAX
                         : {1'b0, transmit_block_size, 1'b0};
  wire tx_take = tx_valid & tx_ready;
  wire blk_full = (tx_cnt + 10'h001) >= blk_limit;
  wire next_tx_ready = ~(hs_on & ~cts_s);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_ready <= 1'b0;
      tx_char_valid <= 1'b0;
      tx_char <= 8'h00;
      tx_par_en <= 1'b0;
      tx_parity <= 1'b0;
      tx_block_end <= 1'b0;
      tx_cnt <= 10'h000;
    end else begin
      tx_ready <= next_tx_ready;
      tx_char_valid <= tx_take;
      tx_block_end <= tx_take & (blk_full | tx_last);
      if (tx_take) begin
        tx_char <= tx_data;
        tx_par_en <= odd_on;
        tx_parity <= odd_on & odd_bit(tx_data);
        tx_cnt <= (blk_full | tx_last) ? 10'h000 : tx_cnt + 10'h001;
      end
    end
  end

  chk_start_marker: assert property (@(posedge pclk) disable iff (!presetn)
    rx_valid && rx_kind == MLCR_START && control_block_mask[MASK_START_BIT]
    |=> in_valid && in_ctrl && in_data == CB_START) else $error("start marker missing");
  chk_etx_marker: assert property (@(posedge pclk) disable iff (!presetn)
    rx_valid && rx_kind == MLCR_ETX && control_block_mask[MASK_ETX_BIT]
    |=> in_valid && in_ctrl && in_data == CB_ETX) else $error("ETX marker missing");
  chk_etb_marker: assert property (@(posedge pclk) disable iff (!presetn)
    rx_valid && rx_kind == MLCR_ETB && control_block_mask[MASK_ETB_BIT]
    |=> in_valid && in_ctrl && in_data == CB_ETB) else $error("ETB marker missing");
  chk_marker_masked: assert property (@(posedge pclk) disable iff (!presetn)
    rx_valid && rx_kind == MLCR_START && !control_block_mask[MASK_START_BIT] |=> !in_valid)
    else $error("masked start marker passed");
  chk_id_range: assert property (@(posedge pclk) disable iff (!presetn)
    group_identifier <= ID_MAX && device_identifier <= ID_MAX) else $error("identifier out of range");
  chk_parity_code: assert property (@(posedge pclk) disable iff (!presetn)
    parity_select <= PAR_ODD) else $error("illegal parity code held");
  chk_unused_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && idx == 6'h19 |=> $stable(line_speed_select) && $stable(parity_select)
    && $stable(hardware_handshake_type)) else $error("unused register write changed settings");
  chk_tx_odd: assert property (@(posedge pclk) disable iff (!presetn)
    tx_char_valid && tx_par_en |-> (^{tx_char, tx_parity}) == 1'b1) else $error("transmit parity not odd");
  chk_dcd_discard: assert property (@(posedge pclk) disable iff (!presetn)
    rx_is_data && hs_on && !dcd_s |=> !in_valid) else $error("data kept while carrier low");
  chk_cts_hold: assert property (@(posedge pclk) disable iff (!presetn)
    hs_on && !cts_s ##1 hs_on && !cts_s |-> !tx_ready && !tx_take) else $error("transmit while CTS low");
  chk_block_512: assert property (@(posedge pclk) disable iff (!presetn)
    tx_take && transmit_block_size == 8'h00 && tx_cnt == 10'h1FF |=> tx_block_end)
    else $error("512-byte block not closed");
  chk_block_2n: assert property (@(posedge pclk) disable iff (!presetn)
    tx_take && transmit_block_size != 8'h00 && tx_cnt + 10'h001 == {1'b0, transmit_block_size, 1'b0}
    |=> tx_block_end) else $error("2N block limit not applied");
  chk_speed_legal: assert property (@(posedge pclk) disable iff (!presetn)
    speed_ok(line_speed_select)) else $error("illegal speed code held");
  cov_etb_block: cover property (@(posedge pclk) disable iff (!presetn) mk_etb ##1 in_valid);
  cov_block_cap: cover property (@(posedge pclk) disable iff (!presetn) tx_block_end && !$past(tx_last));
  cov_perr: cover property (@(posedge pclk) disable iff (!presetn) perr_set);
  cov_cts_stall: cover property (@(posedge pclk) disable iff (!presetn) tx_valid && !tx_ready);
endmodule

// ===== bench/mlcr_host_model.sv
// Network host model: drives inbound events and link pins, collects outbound blocks
`timescale 1ns/10ps
module mlcr_host_model
  import mlcr_pkg::*;
(
  input wire logic pclk,
  input wire logic tx_char_valid,
  input wire logic tx_block_end,
  output logic rx_valid,
  output mlcr_kind_type rx_kind,
  output logic [7:0] rx_data,
  output logic rx_par,
  output logic dcd_pin,
  output logic cts_pin,
  output logic ext_clk_pin
);
  int cur = 0;
  int blks[$];
  initial begin
    rx_valid = 1'b0;
    rx_kind = MLCR_DATA;
    rx_data = 8'h00;
    rx_par = 1'b0;
    dcd_pin = 1'b1;
    cts_pin = 1'b1;
    ext_clk_pin = 1'b0;
  end
  // Host alone picks the moment of each inbound event; released data and parity lines show the inverse
  task automatic send(input mlcr_kind_type k, input logic [7:0] d, input logic p);
    @(posedge pclk);
    rx_valid <= 1'b1;
    rx_kind <= k;
    rx_data <= d;
    rx_par <= p;
    @(posedge pclk);
    rx_valid <= 1'b0;
    rx_data <= ~d;
    rx_par <= ~p;
  endtask
  task automatic pins(input logic d, input logic c);
    @(posedge pclk);
    dcd_pin <= d;
    cts_pin <= c;
  endtask
  // Bit clock from the far side, still outside the burst
  task automatic ext_burst(input int n);
    repeat (n) begin
      repeat (4) @(posedge pclk);
      ext_clk_pin <= 1'b1;
      repeat (4) @(posedge pclk);
      ext_clk_pin <= 1'b0;
    end
  endtask
  always @(posedge pclk) begin
    if (tx_char_valid === 1'b1) begin
      cur++;
      if (tx_block_end === 1'b1) begin
        blks.push_back(cur);
        cur = 0;
      end
    end
  end
endmodule

// ===== bench/tb_multipoint_link_config_regs.sv
// Self-checking bench for the multipoint link configuration registers
`timescale 1ns/10ps
module tb_multipoint_link_config_regs;
  import mlcr_pkg::*;
  localparam int CLK_HZ = 1000000;
  typedef struct {logic [5:0] idx; logic [7:0] wd; logic s; logic [7:0] ex;} mlcr_row_type;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic tx_valid = 1'b0;
  logic [7:0] tx_data = 8'h30;
  logic tx_last = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, rx_valid, rx_par, dcd_pin, cts_pin, ext_clk_pin;
  mlcr_kind_type rx_kind;
  logic [7:0] rx_data, in_data, tx_char, group_identifier_char, device_identifier_char;
  logic in_valid, in_ctrl, in_perr, tx_ready, tx_char_valid, tx_par_en, tx_parity, tx_block_end, baud_tick;
  int bad_count = 0;
  int n_checks = 0;
  int in_cnt = 0;
  int tick_cnt = 0;
  logic l_ctrl, l_perr;
  logic [7:0] l_data;
  logic [31:0] rd_dummy;
  logic [7:0] codes [3] = '{CB_START, CB_ETX, CB_ETB};
  int bauds [9] = '{300, 600, 1200, 1800, 2400, 3600, 4800, 9600, 19200};
  mlcr_row_type rows [13] = '{
    '{IDX_CB_MASK, 8'h07, 1'b1, 8'h07}, '{IDX_SPEED, 8'h0F, 1'b1, 8'h0F},
    '{IDX_SPEED, 8'h05, 1'b1, 8'h0F}, '{IDX_GROUP, 8'h1A, 1'b1, 8'h1A},
    '{IDX_GROUP, 8'h1B, 1'b1, 8'h1A}, '{IDX_DEVICE, 8'h00, 1'b1, 8'h00},
    '{IDX_HS, 8'h03, 1'b1, 8'h03}, '{IDX_HS, 8'h00, 1'b0, 8'h03},
    '{IDX_BSIZE, 8'h82, 1'b1, 8'h82}, '{IDX_PARITY, 8'h01, 1'b1, 8'h01},
    '{IDX_PARITY, 8'h02, 1'b1, 8'h01}, '{6'h19, 8'h55, 1'b1, 8'h00},
    '{6'h25, 8'h55, 1'b1, 8'h00}};
  always #5 pclk = ~pclk;
  mlcr_top #(.CLK_HZ(CLK_HZ)) DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .dcd_pin, .cts_pin, .ext_clk_pin, .rx_valid, .rx_kind, .rx_data, .rx_par,
    .in_valid, .in_ctrl, .in_data, .in_perr, .tx_valid, .tx_data, .tx_last, .tx_ready, .tx_char_valid,
    .tx_char, .tx_par_en, .tx_parity, .tx_block_end, .baud_tick, .group_identifier_char,
    .device_identifier_char);
  mlcr_host_model host (.pclk, .tx_char_valid, .tx_block_end, .rx_valid, .rx_kind, .rx_data, .rx_par,
    .dcd_pin, .cts_pin, .ext_clk_pin);
  always @(posedge pclk) begin
    if (baud_tick === 1'b1) tick_cnt++;
    if (in_valid === 1'b1) begin
      in_cnt++;
      l_ctrl = in_ctrl;
      l_data = in_data;
      l_perr = in_perr;
    end
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic hang(input string nm);
    bad_count++;
    $display("CHECK FAILED %s expected response seen none", nm);
    final_report();
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [5:0] idx, input logic [7:0] d, input logic s,
    output logic [31:0] r);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'hFFFFFF, d};
    pstrb <= {3'b111, s};
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 20) hang("pready");
    chk("pslverr", 0, pslverr);
  endtask
  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    logic [31:0] r;
    apb(1'b1, idx, d, 1'b1, r);
  endtask
  task automatic rdchk(input string nm, input logic [5:0] idx, input logic [7:0] e);
    logic [31:0] r;
    apb(1'b0, idx, 8'h00, 1'b1, r);
    chk(nm, {24'h0, e}, r);
  endtask
  task automatic settle();
    repeat (4) @(posedge pclk);
  endtask
  task automatic wait_tick(output int c);
    c = 0;
    do begin
      @(posedge pclk);
      c++;
    end while (baud_tick !== 1'b1 && c < 5000);
    if (c >= 5000) hang("baud_tick");
  endtask
  // Holds the offer until taken; only the final character closes the block early
  task automatic tx_burst(input int n);
    int k;
    k = 0;
    tx_valid <= 1'b1;
    tx_last <= (n == 1);
    for (int i = 0; i < 4 * n + 20 && k < n; i++) begin
      @(posedge pclk);
      if (tx_ready === 1'b1) begin
        k++;
        tx_data <= tx_data + 8'h01;
        tx_last <= (k == n - 1);
      end
    end
    tx_valid <= 1'b0;
    if (k != n) hang("tx_ready");
    settle();
  endtask
  initial begin
    int n;
    int c;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      apb(1'b1, rows[i].idx, rows[i].wd, rows[i].s, rd_dummy);
      rdchk("reg readback", rows[i].idx, rows[i].ex);
    end
    chk("group char", 8'h5A, group_identifier_char);
    chk("device char", 8'h40, device_identifier_char);
    $display("test register rows done");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdchk("rst mask", IDX_CB_MASK, RST_CB_MASK);
    rdchk("rst speed", IDX_SPEED, RST_SPEED);
    rdchk("rst group", IDX_GROUP, RST_GROUP);
    rdchk("rst device", IDX_DEVICE, RST_DEVICE);
    rdchk("rst hs", IDX_HS, RST_HS);
    rdchk("rst bsize", IDX_BSIZE, RST_BSIZE);
    rdchk("rst parity", IDX_PARITY, RST_PARITY);
    chk("rst chars", 16'h4141, {group_identifier_char, device_identifier_char});
    $display("test reset done");
    for (int b = 0; b < 3; b++) begin
      wr(IDX_CB_MASK, 8'h01 << b);
      for (int k = 1; k < 4; k++) begin
        n = in_cnt;
        host.send(mlcr_kind_type'(k), 8'h00, 1'b0);
        settle();
        chk("marker count", n + (k == b + 1), in_cnt);
        if (k == b + 1) chk("marker code", {1'b1, codes[b]}, {l_ctrl, l_data});
      end
    end
    $display("test markers done");
    wr(IDX_PARITY, PAR_ODD);
    host.send(MLCR_DATA, 8'h03, 1'b0);
    settle();
    chk("perr even", 10'h203, {l_perr, l_ctrl, l_data});
    host.send(MLCR_DATA, 8'h03, 1'b1);
    settle();
    chk("perr odd", 0, l_perr);
    rdchk("perr sticky", IDX_STATUS, 8'h07);
    wr(IDX_STATUS, 8'h01);
    rdchk("perr clear", IDX_STATUS, 8'h06);
    $display("test parity done");
    wr(IDX_HS, 8'h01);
    host.pins(1'b0, 1'b0);
    settle();
    n = in_cnt;
    host.send(MLCR_DATA, 8'h5A, 1'b1);
    settle();
    chk("dcd low drop", n, in_cnt);
    chk("cts low hold", 0, tx_ready);
    host.pins(1'b1, 1'b1);
    settle();
    host.send(MLCR_DATA, 8'h5A, 1'b1);
    settle();
    chk("dcd high keep", {n + 1, 8'h5A}, {in_cnt[23:0], l_data});
    chk("cts high send", 1, tx_ready);
    $display("test handshake done");
    wr(IDX_BSIZE, 8'h02);
    tx_burst(5);
    chk("blk 2N", 2, host.blks.size());
    chk("blk 2N len", 4, host.blks[0]);
    chk("blk 2N tail", 1, host.blks[1]);
    chk("tx parity", 2'b11, {tx_par_en, ^{tx_char, tx_parity}});
    chk("tx char", tx_data - 8'h01, tx_char);
    host.blks.delete();
    wr(IDX_BSIZE, 8'h00);
    tx_burst(513);
    chk("blk 512 len", 512, host.blks[0]);
    chk("blk 512 tail", 1, host.blks[1]);
    $display("test block size done");
    for (int j = 0; j < 9; j++) begin
      wr(IDX_SPEED, 8'(j + 7));
      wait_tick(c);
      wait_tick(c);
      wait_tick(c);
      chk("baud period", CLK_HZ / bauds[j], c);
    end
    wr(IDX_SPEED, SPEED_EXT);
    settle();
    n = tick_cnt;
    host.ext_burst(4);
    settle();
    chk("ext ticks", n + 4, tick_cnt);
    $display("test line speed done");
    final_report();
  end
endmodule
